// File: pkg/mms_map.svh
// Offsets, field positions, reset values and frame sizes of the sublayer parser.
`ifndef MMS_MAP_SVH
`define MMS_MAP_SVH
`define MMS_REG_CTRL      8'h00
`define MMS_REG_STATUS    8'h04
`define MMS_REG_SESS_LOSS 8'h08
`define MMS_REG_HDR_ERR   8'h0c
`define MMS_REG_NULL_INS  8'h10
`define MMS_REG_PROBE     8'h14
`define MMS_REG_IGNORED   8'h18
`define MMS_CTRL_MODE     0
`define MMS_CTRL_NULL     1
`define MMS_CTRL_RESET    2'h3
`define MMS_HDR_LEN       5'h18
`define MMS_TS_LEN        8'hbc
`define MMS_MAX_PKTS      4'ha
`define MMS_H_SESSION     2'h0
`define MMS_H_PROBE       2'h1
`define MMS_NULL_SYNC     8'h47
`define MMS_NULL_PID_HI   8'h1f
`define MMS_NULL_PID_LO   8'hff
`define MMS_NULL_FLAGS    8'h10
`define MMS_NULL_FILL     8'hff
`define MMS_RESP_OKAY     2'h0
`define MMS_RESP_SLVERR   2'h2
`endif

// File: pkg/mms_pkg.sv
// Types shared by the sublayer parser and its users.
`default_nettype none
package mms_pkg;
	typedef struct packed {
		logic [7:0] channel_tag;
		logic       first;
		logic [7:0] data;
	} mms_beat_t;
	typedef enum logic [2:0] {
		ST_HDR  = 3'h0,
		ST_ENT  = 3'h1,
		ST_NUL  = 3'h3,
		ST_PAY  = 3'h2,
		ST_DROP = 3'h6
	} mms_state_t;
endpackage
`default_nettype wire

// File: logic/mms_rx.sv
// Receive parser for the multi-channel transport sublayer header and payload.
// Operation
// - Extended-header 00 session, 01 probe, others undefined.
// - Multichannel parsing chosen by configuration, not bits.
// - Session sequence used only when flag set.
// - Reserved bits sent zero, ignored on receive.
// - Three-bit flow selector extracted from header.
// - Packet count 1..10 legal, others reserved.
// - Only first count array entries are valid.
// - Entries beyond count are zero and ignored.
// - Session sequence increments; receiver detects frame loss.
// - Header is 4 bytes plus fixed 20-byte array.
// - Entry tag selects the destination channel.
// - Per-channel 4-bit sequence tracked per packet.
// - Null packets replace missing channel packets.
// - Up to ten packets of mixed channels.
// - Payload is back-to-back 188-byte transport packets.
// - Null packets are 188 bytes, identifier 0x1fff.
// - Nonconforming sublayer headers are ignored.
`timescale 1ns/1ps
`include "mms_map.svh"
`default_nettype none
module mms_rx (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              s_axil_awvalid,
	output logic                   s_axil_awready,
	input  wire logic [7:0]        s_axil_awaddr,
	input  wire logic              s_axil_wvalid,
	output logic                   s_axil_wready,
	input  wire logic [31:0]       s_axil_wdata,
	input  wire logic [3:0]        s_axil_wstrb,
	output logic                   s_axil_bvalid,
	input  wire logic              s_axil_bready,
	output logic [1:0]             s_axil_bresp,
	input  wire logic              s_axil_arvalid,
	output logic                   s_axil_arready,
	input  wire logic [7:0]        s_axil_araddr,
	output logic                   s_axil_rvalid,
	input  wire logic              s_axil_rready,
	output logic [31:0]            s_axil_rdata,
	output logic [1:0]             s_axil_rresp,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [7:0]        in_data,
	input  wire logic              in_last,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output mms_pkg::mms_beat_t     out_beat
);
	import mms_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic [1:0]  ctrl;
	logic [31:0] sess_loss;
	logic [31:0] hdr_err;
	logic [31:0] null_ins;
	logic [31:0] probe_cnt;
	logic [31:0] ignored;
	logic [5:0]  status;
	mms_state_t  state;
	logic [7:0]  hdr [0:23];
	logic [4:0]  hcnt;
	logic [3:0]  idx;
	logic [3:0]  count;
	logic [7:0]  bcnt;
	logic [3:0]  nulls;
	logic [7:0]  cur_tag;
	logic [3:0]  exp_seq [0:255];
	logic [255:0] seen;
	logic [15:0] sess_exp;
	logic        sess_seen;

	wire take_in   = in_valid && in_ready;
	wire out_free  = !out_valid || out_ready;
	wire hdr_done  = take_in && state == ST_HDR && hcnt == `MMS_HDR_LEN - 5'h1;
	// Field layout of the first header word.
	wire        f_seqv  = hdr[0][6];
	wire [1:0]  f_hbits = hdr[0][5:4];
	wire [2:0]  f_flow  = hdr[0][2:0];
	wire [3:0]  f_count = hdr[1][3:0];
	wire [15:0] f_seq   = {hdr[2], hdr[3]};
	// Connectivity flag and reserved bits are never looked at.
	wire is_probe   = f_hbits == `MMS_H_PROBE;
	wire is_undef   = f_hbits[1];
	wire mode_off   = f_hbits == `MMS_H_SESSION && !ctrl[`MMS_CTRL_MODE];
	wire cnt_bad    = f_count == 4'h0 || f_count > `MMS_MAX_PKTS;
	wire hdr_ok     = !is_probe && !is_undef && !mode_off && !cnt_bad && !in_last;
	wire sess_slip  = f_seqv && sess_seen && f_seq != sess_exp;
	// Entry idx sits at array bytes 4+2*idx; the valid entries are only those below count.
	wire [4:0]  ent_off = 5'h4 + {idx, 1'b0};
	wire [7:0]  ent_tag = hdr[ent_off];
	wire [3:0]  ent_seq = hdr[ent_off + 5'h1][7:4];
	wire [3:0]  ent_gap = seen[ent_tag] ? ent_seq - exp_seq[ent_tag] : 4'h0;
	wire        ent_end = idx == count;
	wire        want_nul = ent_gap != 4'h0 && ctrl[`MMS_CTRL_NULL];
	wire        pay_last = bcnt == `MMS_TS_LEN - 8'h1;
	wire [7:0]  null_byte = bcnt == 8'h0 ? `MMS_NULL_SYNC :
		bcnt == 8'h1 ? `MMS_NULL_PID_HI : bcnt == 8'h2 ? `MMS_NULL_PID_LO :
		bcnt == 8'h3 ? `MMS_NULL_FLAGS : `MMS_NULL_FILL;
	wire emit_nul  = state == ST_NUL && out_free;
	wire emit_pay  = state == ST_PAY && take_in;
	wire pay_ok    = in_last && pay_last && idx + 4'h1 == count;
	wire len_err   = (emit_pay && in_last && !pay_ok) || (state == ST_ENT && ent_end);
	wire ent_start = state == ST_ENT && !ent_end;

	assign in_ready = state == ST_HDR || state == ST_DROP || (state == ST_PAY && out_free);
	assign status   = {f_flow, f_hbits, f_seqv};

	////////////////////////////////////////////////////////////////////////////
	// Frame parser.
	mms_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			ST_HDR: begin
				if (hdr_done) begin
					next_state = hdr_ok ? ST_ENT : (in_last ? ST_HDR : ST_DROP);
				end
			end
			ST_ENT: begin
				if (ent_end) begin
					next_state = ST_DROP;
				end else begin
					next_state = want_nul ? ST_NUL : ST_PAY;
				end
			end
			ST_NUL: begin
				if (emit_nul && pay_last && nulls == 4'h1) begin
					next_state = ST_PAY;
				end
			end
			ST_PAY: begin
				if (emit_pay && in_last) begin
					next_state = ST_HDR;
				end else if (emit_pay && pay_last) begin
					next_state = ST_ENT;
				end
			end
			ST_DROP: begin
				if (take_in && in_last) begin
					next_state = ST_HDR;
				end
			end
			default: next_state = ST_HDR;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_HDR;
			hcnt  <= 5'h0;
			idx   <= 4'h0;
			count <= 4'h0;
			bcnt  <= 8'h0;
			nulls <= 4'h0;
			cur_tag <= 8'h0;
		end else begin
			state <= next_state;
			if (state == ST_HDR && take_in) begin
				hcnt <= (in_last || hdr_done) ? 5'h0 : hcnt + 5'h1;
			end
			if (hdr_done) begin
				idx   <= 4'h0;
				count <= f_count;
			end
			if (ent_start) begin
				cur_tag <= ent_tag;
				nulls   <= want_nul ? ent_gap : 4'h0;
				bcnt    <= 8'h0;
			end
			if (emit_nul) begin
				bcnt <= pay_last ? 8'h0 : bcnt + 8'h1;
				if (pay_last) begin
					nulls <= nulls - 4'h1;
				end
			end
			if (emit_pay) begin
				bcnt <= pay_last ? 8'h0 : bcnt + 8'h1;
				if (pay_last) begin
					idx <= idx + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (state == ST_HDR && take_in) begin
			hdr[hcnt] <= in_data;
		end
	end

	// Channel memory is reset through the seen bits only, which keeps the array itself plain.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen <= 256'h0;
		end else if (ent_start) begin
			seen[ent_tag] <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (ent_start) begin
			exp_seq[ent_tag] <= ent_seq + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output stage: one registered beat, refilled whenever the sink has taken it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_beat  <= '0;
		end else if (emit_nul) begin
			out_valid <= 1'b1;
			out_beat  <= '{channel_tag: cur_tag, first: bcnt == 8'h0, data: null_byte};
		end else if (emit_pay) begin
			out_valid <= 1'b1;
			out_beat  <= '{channel_tag: cur_tag, first: bcnt == 8'h0, data: in_data};
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Session tracking and event counters.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sess_exp  <= 16'h0;
			sess_seen <= 1'b0;
			sess_loss <= 32'h0;
			hdr_err   <= 32'h0;
			null_ins  <= 32'h0;
			probe_cnt <= 32'h0;
			ignored   <= 32'h0;
		end else begin
			if (hdr_done && hdr_ok && f_seqv) begin
				sess_exp  <= f_seq + 16'h1;
				sess_seen <= 1'b1;
			end
			if (hdr_done && hdr_ok && sess_slip) begin
				sess_loss <= sess_loss + 32'h1;
			end
			if ((hdr_done && !is_probe && !is_undef && !mode_off && (cnt_bad || in_last))
				|| len_err) begin
				hdr_err <= hdr_err + 32'h1;
			end
			if (emit_nul && pay_last) begin
				null_ins <= null_ins + 32'h1;
			end
			if (hdr_done && is_probe) begin
				probe_cnt <= probe_cnt + 32'h1;
			end
			if (hdr_done && (is_undef || mode_off)) begin
				ignored <= ignored + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register slave: write address and data are taken together in one cycle.
	wire wr_take = s_axil_awvalid && s_axil_wvalid && !s_axil_bvalid;
	wire rd_take = s_axil_arvalid && !s_axil_rvalid;
	wire wr_ctrl = s_axil_awaddr == `MMS_REG_CTRL;
	wire [2:0] rd_sel = s_axil_araddr[4:2];
	wire rd_hit = s_axil_araddr[1:0] == 2'h0 && s_axil_araddr <= `MMS_REG_IGNORED;
	wire [31:0] rd_word = rd_sel == 3'h0 ? {30'h0, ctrl} :
		rd_sel == 3'h1 ? {26'h0, status} : rd_sel == 3'h2 ? sess_loss :
		rd_sel == 3'h3 ? hdr_err : rd_sel == 3'h4 ? null_ins :
		rd_sel == 3'h5 ? probe_cnt : ignored;

	assign s_axil_awready = wr_take;
	assign s_axil_wready  = wr_take;
	assign s_axil_arready = rd_take;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl          <= `MMS_CTRL_RESET;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= `MMS_RESP_OKAY;
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= 32'h0;
			s_axil_rresp  <= `MMS_RESP_OKAY;
		end else begin
			if (wr_take) begin
				s_axil_bvalid <= 1'b1;
				s_axil_bresp  <= wr_ctrl ? `MMS_RESP_OKAY : `MMS_RESP_SLVERR;
				if (wr_ctrl && s_axil_wstrb[0]) begin
					ctrl <= s_axil_wdata[1:0];
				end
			end else if (s_axil_bready) begin
				s_axil_bvalid <= 1'b0;
			end
			if (rd_take) begin
				s_axil_rvalid <= 1'b1;
				s_axil_rdata  <= rd_hit ? rd_word : 32'h0;
				s_axil_rresp  <= rd_hit ? `MMS_RESP_OKAY : `MMS_RESP_SLVERR;
			end else if (s_axil_rready) begin
				s_axil_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	hdr_probe_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hdr_done && is_probe |=> probe_cnt == $past(probe_cnt) + 32'h1 && state != ST_ENT)
		else $error("probe header not counted or parsed");
	mode_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hdr_done && mode_off |=> state != ST_ENT)
		else $error("session header parsed while multichannel mode off");
	sess_loss_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hdr_done && !f_seqv |=> sess_loss == $past(sess_loss))
		else $error("session loss counted with sequence flag clear");
	cnt_bad_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hdr_done && cnt_bad && !is_probe && !is_undef && !mode_off
		|=> hdr_err == $past(hdr_err) + 32'h1 && state != ST_ENT)
		else $error("reserved packet count not flagged");
	null_pid_a: assert property (@(posedge aclk) disable iff (!aresetn)
		emit_nul && bcnt == 8'h1 |=> out_beat.data == `MMS_NULL_PID_HI ##1
		(!out_valid || out_beat.data == `MMS_NULL_PID_LO || $stable(out_beat)))
		else $error("null packet identifier wrong");
	seq_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ent_start |=> seen[$past(ent_tag)] && exp_seq[$past(ent_tag)] == $past(ent_seq) + 4'h1)
		else $error("channel expectation not updated");
	null_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ent_start && !want_nul |=> state == ST_PAY)
		else $error("nulls inserted without a gap");
	out_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		out_valid && !out_ready |=> out_valid && $stable(out_beat))
		else $error("output beat changed under back-pressure");
	len_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state == ST_ENT && ent_end |=> state == ST_DROP && hdr_err == $past(hdr_err) + 32'h1)
		else $error("surplus payload not flagged");
endmodule // mms_rx
`default_nettype wire

// File: testbench/mms_headend.sv
// Headend-side model that sends sublayer frames into the parser.
`timescale 1ns/1ps
`default_nettype none
module mms_headend (
	input  wire logic       aclk,
	input  wire logic       in_ready,
	output var  logic       in_valid,
	output var  logic [7:0] in_data,
	output var  logic       in_last
);
	// A fixed start keeps runs repeatable; the value itself is arbitrary.
	logic [15:0] sess = 16'h5a3c;
	logic        seqv = 1'b1;
	logic        ok;
	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		in_last = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic put(input logic [7:0] b, input logic l);
		in_valid <= 1'b1;
		in_data <= b;
		in_last <= l;
		do begin
			@(negedge aclk);
			ok = in_ready;
			@(posedge aclk);
		end while (ok !== 1'b1);
	endtask
	task automatic frame(input logic [1:0] h, input logic [3:0] cnt, input int npay,
		input logic [7:0] tg, input logic [3:0] sq);
		logic [7:0] hd [24];
		@(posedge aclk);
		hd = '{default: 8'h00};
		hd[0] = {1'b0, seqv, h, 1'b0, 3'h5};
		hd[1] = {4'h0, cnt};
		hd[2] = sess[15:8];
		hd[3] = sess[7:0];
		for (int i = 0; i < 10; i++) begin
			if (i < cnt) begin
				hd[4 + 2 * i] = tg + 8'(i);
				hd[5 + 2 * i] = {sq, 4'h0};
			end
		end
		for (int i = 0; i < 24; i++) put(hd[i], npay == 0 && i == 23);
		for (int k = 0; k < npay; k++) begin
			for (int j = 0; j < 188; j++) put(8'(k ^ j), k == npay - 1 && j == 187);
		end
		// A released line shows the inverse so a stale byte is never mistaken for data.
		in_valid <= 1'b0;
		in_data <= ~in_data;
		in_last <= 1'b0;
		sess = sess + 16'h1;
	endtask
endmodule // mms_headend
`default_nettype wire

// File: testbench/test_multichannel_mpeg_sublayer.sv
// Self-checking bench for the sublayer parser.
`timescale 1ns/1ps
`include "mms_map.svh"
`default_nettype none
module test_multichannel_mpeg_sublayer;
	import mms_pkg::*;
	typedef struct {
		logic [1:0] h;
		logic [3:0] cnt;
		int         npay;
		logic [7:0] tag;
		int         nout;
	} mms_row_t;
	logic        aclk = 1'b0, aresetn = 1'b0, out_ready = 1'b1, slow = 1'b0;
	logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
	logic        s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
	logic [7:0]  s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
	logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, rd;
	logic [3:0]  s_axil_wstrb = 4'hf;
	logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
	logic [1:0]  s_axil_bresp, s_axil_rresp, rs;
	logic        in_valid, in_ready, in_last, out_valid;
	logic [7:0]  in_data;
	mms_beat_t   out_beat;
	mms_beat_t   exp_q[$], got_q[$];
	int          n_fail = 0, compares = 0, cyc = 0;
	mms_row_t    rows[7] = '{'{2'h0, 4'h1, 1, 8'h10, 1}, '{2'h0, 4'ha, 10, 8'h20, 10},
		'{2'h1, 4'h1, 1, 8'h50, 0}, '{2'h2, 4'h1, 1, 8'h58, 0}, '{2'h3, 4'h1, 1, 8'h60, 0},
		'{2'h0, 4'h0, 1, 8'h68, 0}, '{2'h0, 4'hb, 1, 8'h70, 0}};
	mms_rx mms_rx_i (.aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_awaddr,
		.s_axil_wvalid, .s_axil_wready, .s_axil_wdata, .s_axil_wstrb, .s_axil_bvalid,
		.s_axil_bready, .s_axil_bresp, .s_axil_arvalid, .s_axil_arready, .s_axil_araddr,
		.s_axil_rvalid, .s_axil_rready, .s_axil_rdata, .s_axil_rresp, .in_valid, .in_ready,
		.in_data, .in_last, .out_valid, .out_ready, .out_beat);
	mms_headend mms_headend_i (.aclk, .in_ready, .in_valid, .in_data, .in_last);
	initial forever #50 aclk = ~aclk;
	always @(posedge aclk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got_q.push_back(out_beat);
		out_ready <= slow ? ~out_ready : 1'b1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			n_fail++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic push_pkt(input logic [7:0] tag, input logic nul, input int k);
		logic [7:0] d;
		for (int j = 0; j < 188; j++) begin
			d = nul ? `MMS_NULL_FILL : 8'(k ^ j);
			if (nul && j == 0) d = `MMS_NULL_SYNC;
			if (nul && j == 1) d = `MMS_NULL_PID_HI;
			if (nul && j == 3) d = `MMS_NULL_FLAGS;
			exp_q.push_back(mms_beat_t'{tag, j == 0, d});
		end
	endtask
	task automatic settle();
		for (int i = 0; i < 600 && got_q.size() < exp_q.size(); i++) @(posedge aclk);
		repeat (4) @(posedge aclk);
		chk(got_q.size(), exp_q.size());
		foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i]);
		exp_q.delete();
		got_q.delete();
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axil_awvalid <= 1'b1;
		s_axil_awaddr <= a;
		s_axil_wvalid <= 1'b1;
		s_axil_wdata <= d;
		s_axil_bready <= 1'b1;
		fork
			begin
				do @(negedge aclk); while (s_axil_awready !== 1'b1);
				@(posedge aclk);
				s_axil_awvalid <= 1'b0;
			end
			begin
				do @(negedge aclk); while (s_axil_wready !== 1'b1);
				@(posedge aclk);
				s_axil_wvalid <= 1'b0;
			end
		join
		do @(negedge aclk); while (s_axil_bvalid !== 1'b1);
		rs = s_axil_bresp;
		@(posedge aclk);
		s_axil_bready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] want, input logic [1:0] wr = 2'h0);
		@(posedge aclk);
		s_axil_arvalid <= 1'b1;
		s_axil_araddr <= a;
		s_axil_rready <= 1'b1;
		do @(negedge aclk); while (s_axil_arready !== 1'b1);
		@(posedge aclk);
		s_axil_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axil_rvalid !== 1'b1);
		rd = s_axil_rdata;
		rs = s_axil_rresp;
		@(posedge aclk);
		s_axil_rready <= 1'b0;
		chk(rd, want);
		chk(32'(rs), 32'(wr));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h00, 32'h3);
		rc(8'h0c, 32'h0);
		foreach (rows[i]) begin
			for (int k = 0; k < rows[i].nout; k++) push_pkt(rows[i].tag + 8'(k), 1'b0, k);
			mms_headend_i.frame(rows[i].h, rows[i].cnt, rows[i].npay, rows[i].tag, 4'h0);
			settle();
		end
		rc(8'h14, 32'h1);
		rc(8'h18, 32'h2);
		rc(8'h0c, 32'h2);
		// Channel 0x10 last carried 0, so 3 leaves two packets missing.
		slow <= 1'b1;
		push_pkt(8'h10, 1'b1, 0);
		push_pkt(8'h10, 1'b1, 0);
		push_pkt(8'h10, 1'b0, 0);
		mms_headend_i.frame(2'h0, 4'h1, 1, 8'h10, 4'h3);
		settle();
		slow <= 1'b0;
		rc(8'h10, 32'h2);
		rc(8'h04, 32'h29);
		// The dropped rows never moved the expectation, so the null frame already counts one slip.
		rc(8'h08, 32'h1);
		mms_headend_i.sess++;
		push_pkt(8'h10, 1'b0, 0);
		mms_headend_i.frame(2'h0, 4'h1, 1, 8'h10, 4'h4);
		settle();
		rc(8'h08, 32'h2);
		// A frame without the sequence flag carries a wild number that must not count as loss.
		mms_headend_i.seqv = 1'b0;
		mms_headend_i.sess = ~mms_headend_i.sess;
		push_pkt(8'h30, 1'b0, 0);
		mms_headend_i.frame(2'h0, 4'h1, 1, 8'h30, 4'h0);
		settle();
		rc(8'h04, 32'h28);
		rc(8'h08, 32'h2);
		mms_headend_i.seqv = 1'b1;
		mms_headend_i.sess = ~(mms_headend_i.sess - 16'h1);
		axw(8'h00, 32'h1);
		chk(32'(rs), 32'h0);
		push_pkt(8'h10, 1'b0, 0);
		mms_headend_i.frame(2'h0, 4'h1, 1, 8'h10, 4'h8);
		settle();
		rc(8'h10, 32'h2);
		axw(8'h00, 32'h0);
		mms_headend_i.frame(2'h0, 4'h1, 1, 8'h78, 4'h0);
		settle();
		rc(8'h18, 32'h3);
		axw(8'h00, 32'h3);
		push_pkt(8'h40, 1'b0, 0);
		mms_headend_i.frame(2'h0, 4'h2, 1, 8'h40, 4'h0);
		settle();
		rc(8'h0c, 32'h3);
		// One packet more than the count: the first is forwarded, the surplus is dropped.
		push_pkt(8'h48, 1'b0, 0);
		mms_headend_i.frame(2'h0, 4'h1, 2, 8'h48, 4'h0);
		settle();
		rc(8'h0c, 32'h4);
		// A write with no byte lanes enabled must leave control untouched.
		s_axil_wstrb <= 4'h0;
		axw(8'h00, 32'h0);
		s_axil_wstrb <= 4'hf;
		chk(32'(rs), 32'h0);
		rc(8'h00, 32'h3);
		rc(8'h1c, 32'h0, 2'h2);
		axw(8'h08, 32'h5);
		chk(32'(rs), 32'h2);
		// Reset again mid-run: counters, control and channel memory all start over.
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({s_axil_bvalid, s_axil_rvalid, out_valid, in_ready}, 32'h1);
		aresetn <= 1'b1;
		rc(8'h0c, 32'h0);
		rc(8'h00, 32'h3);
		// Channel 0x10 expected 9 before reset, so a kept memory would insert twelve nulls here.
		push_pkt(8'h10, 1'b0, 0);
		mms_headend_i.frame(2'h0, 4'h1, 1, 8'h10, 4'h5);
		settle();
		rc(8'h10, 32'h0);
		test_done();
	end
endmodule // test_multichannel_mpeg_sublayer
`default_nettype wire
